// File: hw/jbtu_top.sv
// Purpose: next-address logic for jumps and branches with one delay slot
// Assumes: one instruction presented per cycle, req.valid marks a
//          control-transfer instruction whose slot is the next one
// Notes:   no stall input; fetch consumes fetch_pc every cycle
//
// Contract
// - each jump or branch delays one cycle; delay slot runs meanwhile
// - absolute jump target is pc top four bits, target field shifted two
// - upper target bits come from the delay-slot address
// - absolute call writes address after delay slot into link register
// - register jump goes to full 32-bit source register value
// - register call jumps, writes after-slot address to destination register
// - branch target is sign-extended shifted offset plus delay-slot address
// - untaken likely branch annuls its delay-slot instruction
// - jumps always execute their delay-slot instruction
`include "jbtu_consts.svh"
`default_nettype none
module jbtu_top
  import jbtu_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire jbtu_req_t  req,
  output logic [31:0]     fetch_pc,
  output logic            slot_annul,
  output jbtu_link_t      link_wr
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  jbtu_regs_t r_q;
  jbtu_regs_t r_d;

  logic [31:0] slot_pc;
  logic [31:0] abs_target;
  logic [31:0] rel_target;
  logic [31:0] reg_target;
  logic [31:0] return_addr;
  logic        taken;
  logic [31:0] dest;

  // the transfer sits at fetch_pc now, so its delay slot is the next word;
  // targets and link values must be formed from that slot address
  assign slot_pc = r_q.pc + `JBTU_INSN_BYTES;

  jbtu_target_calc u_calc (
    .slot_pc     (slot_pc),
    .target      (req.target),
    .offset      (req.offset),
    .src_value   (req.src_value),
    .abs_target  (abs_target),
    .rel_target  (rel_target),
    .reg_target  (reg_target),
    .return_addr (return_addr)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    taken = 1'b0;
    dest = abs_target;
    r_d.link = '0;
    r_d.annul = 1'b0;
    r_d.redirect_pend = 1'b0;
    case (req.op)
      JBTU_OP_JUMP, JBTU_OP_JUMP_CALL: begin
        taken = 1'b1;
        dest = abs_target;
      end
      JBTU_OP_JREG, JBTU_OP_JREG_CALL: begin
        taken = 1'b1;
        dest = reg_target;
      end
      JBTU_OP_BRANCH, JBTU_OP_BRANCH_LIKELY: begin
        taken = req.cond;
        dest = rel_target;
      end
      default: begin
        taken = 1'b0;
      end
    endcase
    // an instruction presented while in the slot is the slot itself;
    // a transfer there is not honoured, the sequence is undefined anyway
    if (req.valid && r_q.state == JBTU_SEQ) begin
      r_d.state = JBTU_SLOT;
      if (req.op == JBTU_OP_JUMP_CALL) begin
        r_d.link.we = 1'b1;
        r_d.link.addr = `JBTU_LINK_REG;
        r_d.link.data = return_addr;
      end else if (req.op == JBTU_OP_JREG_CALL) begin
        r_d.link.we = 1'b1;
        r_d.link.addr = req.dest_reg;
        r_d.link.data = return_addr;
      end else if (req.link_branch && (req.op == JBTU_OP_BRANCH ||
                                      req.op == JBTU_OP_BRANCH_LIKELY)) begin
        r_d.link.we = 1'b1;
        r_d.link.addr = `JBTU_LINK_REG;
        r_d.link.data = return_addr;
      end
      // jumps never annul; only untaken likely branches do
      r_d.annul = (req.op == JBTU_OP_BRANCH_LIKELY) && !req.cond;
      r_d.redirect_pend = taken;
      r_d.redirect = dest;
      r_d.pc = r_q.pc + `JBTU_INSN_BYTES;
    end else if (r_q.state == JBTU_SLOT) begin
      r_d.state = JBTU_SEQ;
      if (r_q.redirect_pend) begin
        r_d.pc = r_q.redirect;
      end else begin
        r_d.pc = r_q.pc + `JBTU_INSN_BYTES;
      end
    end else begin
      r_d.pc = r_q.pc + `JBTU_INSN_BYTES;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r_q <= '{state: JBTU_SEQ, pc: `JBTU_RESET_PC, redirect: 32'h0000_0000,
               redirect_pend: 1'b0, annul: 1'b0, link: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign fetch_pc   = r_q.pc;
  assign slot_annul = r_q.annul;
  assign link_wr    = r_q.link;

endmodule
`default_nettype wire

// File: include/jbtu_consts.svh
// Purpose: constants for the jump and branch target unit
// Assumes: 32-bit instructions at byte addresses, four bytes apart
// Notes:   reset pc value is a plain default
`ifndef JBTU_CONSTS_SVH
`define JBTU_CONSTS_SVH

`define JBTU_RESET_PC     32'h0000_0000
`define JBTU_INSN_BYTES   32'h0000_0004
`define JBTU_LINK_REG     5'h1f
`define JBTU_TGT_W        26
`define JBTU_OFS_W        16
`define JBTU_PC_HI_W      4

`endif

// File: include/jbtu_pkg.sv
// Purpose: types for the jump and branch target unit
// Assumes: decoder classifies control transfers
// Notes:   none
`default_nettype none
package jbtu_pkg;

  typedef enum logic [2:0] {
    JBTU_OP_NONE,
    JBTU_OP_JUMP,
    JBTU_OP_JUMP_CALL,
    JBTU_OP_JREG,
    JBTU_OP_JREG_CALL,
    JBTU_OP_BRANCH,
    JBTU_OP_BRANCH_LIKELY
  } jbtu_op_t;

  typedef struct packed {
    logic        valid;
    jbtu_op_t    op;
    logic        cond;
    logic [25:0] target;
    logic [15:0] offset;
    logic [31:0] src_value;
    logic [4:0]  dest_reg;
    logic        link_branch;
  } jbtu_req_t;

  typedef struct packed {
    logic        we;
    logic [4:0]  addr;
    logic [31:0] data;
  } jbtu_link_t;

  typedef enum logic [1:0] {
    JBTU_SEQ,
    JBTU_SLOT
  } jbtu_state_t;

  typedef struct packed {
    jbtu_state_t state;
    logic [31:0] pc;
    logic [31:0] redirect;
    logic        redirect_pend;
    logic        annul;
    jbtu_link_t  link;
  } jbtu_regs_t;

endpackage
`default_nettype wire

// File: hw/jbtu_target_calc.sv
// Purpose: combinational target and link address formation
// Assumes: slot_pc is the delay-slot address
// Notes:   pure logic, no state
`include "jbtu_consts.svh"
`default_nettype none
module jbtu_target_calc
  import jbtu_pkg::*;
(
  input  wire logic [31:0] slot_pc,
  input  wire logic [25:0] target,
  input  wire logic [15:0] offset,
  input  wire logic [31:0] src_value,
  output logic      [31:0] abs_target,
  output logic      [31:0] rel_target,
  output logic      [31:0] reg_target,
  output logic      [31:0] return_addr
);

  // upper bits come from the slot pc, so a jump in the last word of a
  // region lands in the next region
  assign abs_target  = {slot_pc[31:28], target, 2'b00};
  assign rel_target  = slot_pc + {{14{offset[15]}}, offset, 2'b00};
  assign reg_target  = src_value;
  assign return_addr = slot_pc + `JBTU_INSN_BYTES;

endmodule
`default_nettype wire

// File: bench/jbtu_properties.sv
// Purpose: port assertions for jbtu_top
// Assumes: r_q holds each accepted request, taken or not, through its slot
// Notes:   pc_q lags fetch_pc one cycle
`default_nettype none
module jbtu_properties
  import jbtu_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire jbtu_req_t   req,
  input wire logic [31:0] fetch_pc,
  input wire logic        slot_annul,
  input wire jbtu_link_t  link_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        t_q;
  logic [31:0] pc_q;
  jbtu_req_t   r_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      t_q <= 1'b0;
      pc_q <= '0;
      r_q <= '0;
    end else begin
      t_q <= req.valid && !t_q;
      pc_q <= fetch_pc;
      if (req.valid && !t_q) r_q <= req;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----
  // a transfer, then its slot cycle
  // ----
  sequence s_slot;
    req.valid && !t_q ##1 t_q;
  endsequence
  AST_STEP: assert property (!req.valid && !t_q |=> fetch_pc == pc_q + 32'h4)
    else $error("pc not sequential");
  AST_SLOT: assert property (req.valid && !t_q |=> fetch_pc == pc_q + 32'h4)
    else $error("slot address wrong");
  AST_ABS: assert property (s_slot ##0 r_q.op inside {JBTU_OP_JUMP, JBTU_OP_JUMP_CALL}
    |=> fetch_pc == {pc_q[31:28], r_q.target, 2'b00}) else $error("jump target wrong");
  AST_REG: assert property (s_slot ##0 r_q.op inside {JBTU_OP_JREG, JBTU_OP_JREG_CALL}
    |=> fetch_pc == r_q.src_value) else $error("register target wrong");
  AST_REL: assert property (s_slot ##0 r_q.op inside {JBTU_OP_BRANCH, JBTU_OP_BRANCH_LIKELY}
    |=> fetch_pc == pc_q + (r_q.cond ? {{14{r_q.offset[15]}}, r_q.offset, 2'b00} : 32'h4))
    else $error("branch target wrong");
  AST_ANNUL: assert property (t_q |-> slot_annul == (r_q.op == JBTU_OP_BRANCH_LIKELY && !r_q.cond))
    else $error("annul wrong");
  AST_CALL: assert property (t_q && r_q.op == JBTU_OP_JUMP_CALL
    |-> link_wr == {1'b1, 5'h1f, fetch_pc + 32'h4}) else $error("call link wrong");
  AST_RCALL: assert property (t_q && r_q.op == JBTU_OP_JREG_CALL
    |-> link_wr == {1'b1, r_q.dest_reg, fetch_pc + 32'h4}) else $error("reg link wrong");
endmodule
bind jbtu_top jbtu_properties chk (.clk_sys(clk_sys), .reset(reset), .req(req),
  .fetch_pc(fetch_pc), .slot_annul(slot_annul), .link_wr(link_wr));
`default_nettype wire

// File: bench/jbtu_rf_model.sv
// Purpose: register file beside the fetch stage
// Assumes: writes land on clk_sys
// Notes:   fetch side just consumes fetch_pc, so only writes are kept
`default_nettype none
module jbtu_rf_model
  import jbtu_pkg::*;
(
  input wire logic       clk_sys,
  input wire jbtu_link_t link_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] regs [32];
  always @(posedge clk_sys) if (link_wr.we) regs[link_wr.addr] <= link_wr.data;
endmodule
`default_nettype wire

// File: bench/jbtu_top_bench.sv
// Purpose: self-checking bench for jbtu_top
// Assumes: a plain cycle follows every transfer
// Notes:   pc is tracked here, never read back
`default_nettype none
module jbtu_top_bench
  import jbtu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  jbtu_req_t   req = '0;
  logic [31:0] fetch_pc;
  logic        slot_annul;
  jbtu_link_t  link_wr;
  logic [31:0] pc;
  int          miscompares = 0;
  int          checks = 0;
  always #2 clk_sys = ~clk_sys;
  jbtu_top dut (.clk_sys(clk_sys), .reset(reset), .req(req), .fetch_pc(fetch_pc),
    .slot_annul(slot_annul), .link_wr(link_wr));
  jbtu_rf_model rf (.clk_sys(clk_sys), .link_wr(link_wr));
  // ----
  // tasks
  // ----
  task automatic cmp(string n, logic [37:0] e, logic [37:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic step;
    @(negedge clk_sys);
    pc += 32'h4;
    cmp("pc", pc, fetch_pc);
  endtask
  task automatic go(jbtu_op_t op, logic c, logic an, logic [37:0] lk, logic [31:0] tg);
    req.valid = 1'b1;
    req.op = op;
    req.cond = c;
    step();
    req.valid = 1'b0;
    cmp("annul", an, slot_annul);
    cmp("link we", lk[37], link_wr.we);
    if (lk[37]) cmp("link", lk, link_wr);
    @(negedge clk_sys);
    pc = tg;
    cmp("target", pc, fetch_pc);
    step();
  endtask
  task automatic mid_reset;
    @(negedge clk_sys);
    reset = 1'b1;
    @(negedge clk_sys);
    cmp("reset pc", 32'h0000_0000, fetch_pc);
    cmp("reset annul", 1'b0, slot_annul);
    cmp("reset link we", 1'b0, link_wr.we);
    reset = 1'b0;
    pc = '0;
    step();
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    logic [31:0] ra;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    pc = '0;
    step();
    req.src_value = 32'h0fff_fff8;
    go(JBTU_OP_JREG, 1'b0, 1'b0, '0, 32'h0fff_fff8);
    req.target = 26'h2aa_aaaa;
    go(JBTU_OP_JUMP, 1'b0, 1'b0, '0, {4'h1, 26'h2aa_aaaa, 2'b00});
    ra = pc + 32'h8;
    go(JBTU_OP_JUMP_CALL, 1'b0, 1'b0, {1'b1, 5'h1f, ra}, {pc[31:28], 26'h2aa_aaaa, 2'b00});
    cmp("link reg", ra, rf.regs[31]);
    req.src_value = 32'h0000_1000;
    req.dest_reg = 5'h07;
    go(JBTU_OP_JREG_CALL, 1'b0, 1'b0, {1'b1, 5'h07, pc + 32'h8}, 32'h0000_1000);
    mid_reset();
    req.offset = 16'h8000;
    go(JBTU_OP_BRANCH, 1'b1, 1'b0, '0, pc + 32'h4 - 32'h0002_0000);
    go(JBTU_OP_BRANCH, 1'b0, 1'b0, '0, pc + 32'h8);
    req.offset = 16'h0010;
    req.link_branch = 1'b1;
    go(JBTU_OP_BRANCH, 1'b1, 1'b0, {1'b1, 5'h1f, pc + 32'h8}, pc + 32'h44);
    req.link_branch = 1'b0;
    go(JBTU_OP_BRANCH_LIKELY, 1'b0, 1'b1, '0, pc + 32'h8);
    go(JBTU_OP_BRANCH_LIKELY, 1'b1, 1'b0, '0, pc + 32'h44);
    report_and_stop();
  end
  initial begin
    #5000;
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
